// File: bst_pkg.sv
`default_nettype none

package bst_pkg;

	// scan path geometry
	localparam int unsigned IR_W       = 3;
	localparam int unsigned ID_W       = 32;
	localparam int unsigned BSR_W      = 107;
	localparam int unsigned OE_CELL    = 47;
	localparam int unsigned TLR_TMS_N  = 5;

	// instruction codes; 011, 101 and 110 are reserved
	localparam logic [2:0] INS_EXTEST  = 3'h0;
	localparam logic [2:0] INS_IDCODE  = 3'h1;
	localparam logic [2:0] INS_SAMPZ   = 3'h2;
	localparam logic [2:0] INS_SAMPLE  = 3'h4;
	localparam logic [2:0] INS_BYPASS  = 3'h7;

	// capture pattern for the low instruction bits
	localparam logic [1:0] IR_CAP_PAT  = 2'h1;
	// identification presence bit
	localparam logic       ID_PRESENT  = 1'h1;
	// preset of the output-enable cell
	localparam logic       OE_PRESET   = 1'h1;

	// test access port controller states
	typedef enum logic [3:0] {
		ST_TLR   = 4'h0,
		ST_RTI   = 4'h1,
		ST_SELDR = 4'h2,
		ST_CAPDR = 4'h3,
		ST_SHDR  = 4'h4,
		ST_EX1DR = 4'h5,
		ST_PADR  = 4'h6,
		ST_EX2DR = 4'h7,
		ST_UPDDR = 4'h8,
		ST_SELIR = 4'h9,
		ST_CAPIR = 4'hA,
		ST_SHIR  = 4'hB,
		ST_EX1IR = 4'hC,
		ST_PAIR  = 4'hD,
		ST_EX2IR = 4'hE,
		ST_UPDIR = 4'hF
	} bst_state_t;

endpackage

`default_nettype wire

// File: bst_sync.sv
`timescale 1ns/10ps
`default_nettype none

// two-stage synchroniser for levels entering a clock domain
module bst_sync
	import bst_pkg::*;
#(
	parameter int unsigned W = 1
) (
	input  wire logic         i_clk,    // destination clock
	input  wire logic         i_reset,  // async reset, active high
	input  wire logic [W-1:0] i_d,      // level from the other domain
	output logic      [W-1:0] o_q       // synchronised level
);

	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	// first stage feeds only the second stage
	always_comb begin
		meta_nxt = i_d;
		q_nxt    = meta_r;
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			meta_r <= '0;
			q_r    <= '0;
		end else begin
			meta_r <= meta_nxt;
			q_r    <= q_nxt;
		end
	end

	assign o_q = q_r;

endmodule

`default_nettype wire

// File: bst_fsm.sv
`timescale 1ns/10ps
`default_nettype none

// sixteen-state controller, steps on each rising test clock edge
module bst_fsm
	import bst_pkg::*;
(
	input  wire logic i_tck,     // test clock
	input  wire logic i_reset,   // power-up reset, async, active high
	input  wire logic i_tms,     // mode select
	output bst_state_t o_state   // current state
);

	bst_state_t state_r;
	bst_state_t state_nxt;

	// standard walk; five highs from any state land in reset
	always_comb begin
		unique case (state_r)
			ST_TLR:   state_nxt = i_tms ? ST_TLR   : ST_RTI;
			ST_RTI:   state_nxt = i_tms ? ST_SELDR : ST_RTI;
			ST_SELDR: state_nxt = i_tms ? ST_SELIR : ST_CAPDR;
			ST_CAPDR: state_nxt = i_tms ? ST_EX1DR : ST_SHDR;
			ST_SHDR:  state_nxt = i_tms ? ST_EX1DR : ST_SHDR;
			ST_EX1DR: state_nxt = i_tms ? ST_UPDDR : ST_PADR;
			ST_PADR:  state_nxt = i_tms ? ST_EX2DR : ST_PADR;
			ST_EX2DR: state_nxt = i_tms ? ST_UPDDR : ST_SHDR;
			ST_UPDDR: state_nxt = i_tms ? ST_SELDR : ST_RTI;
			ST_SELIR: state_nxt = i_tms ? ST_TLR   : ST_CAPIR;
			ST_CAPIR: state_nxt = i_tms ? ST_EX1IR : ST_SHIR;
			ST_SHIR:  state_nxt = i_tms ? ST_EX1IR : ST_SHIR;
			ST_EX1IR: state_nxt = i_tms ? ST_UPDIR : ST_PAIR;
			ST_PAIR:  state_nxt = i_tms ? ST_EX2IR : ST_PAIR;
			ST_EX2IR: state_nxt = i_tms ? ST_UPDIR : ST_SHIR;
			ST_UPDIR: state_nxt = i_tms ? ST_SELDR : ST_RTI;
		endcase
	end

	// power-up lands in reset without any clock edge
	always_ff @(posedge i_tck or posedge i_reset) begin
		if (i_reset) begin
			state_r <= ST_TLR;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign o_state = state_r;

	////////////////////////////////////////////////////////////////////////

	sequence s_five_high;
		i_tms [*5];
	endsequence

	property p_five_high;
		@(posedge i_tck) disable iff (i_reset)
		s_five_high |=> (state_r == ST_TLR);
	endproperty
	a_five_high: assert property (p_five_high)
		else $error("five high mode selects did not reach reset");

	property p_walk;
		@(posedge i_tck) disable iff (i_reset)
		(state_r == ST_TLR) && !i_tms ##1 !i_tms |=> (state_r == ST_RTI);
	endproperty
	a_walk: assert property (p_walk)
		else $error("controller did not settle in run-test-idle");

endmodule

`default_nettype wire

// File: bst_top.sv
`timescale 1ns/10ps
`default_nettype none

module bst_top
	import bst_pkg::*;
#(
	parameter logic [2:0]  ID_REV   = 3'h0,      // revision, arbitrary
	parameter logic [16:0] ID_PART  = 17'h0A5A5, // part code, arbitrary
	parameter logic [10:0] ID_MAKER = 11'h2C3    // maker code, arbitrary
) (
	input  wire logic             i_clk_sys,   // memory-side clock
	input  wire logic             i_reset,     // power-up reset, async, high
	input  wire logic             i_tck,       // test clock
	input  wire logic             i_tms,       // mode select
	input  wire logic             i_tdi,       // serial data in
	output logic                  o_tdo,       // serial data out
	output logic                  o_tdo_oe,    // serial out driven when high
	input  wire logic [BSR_W-1:0] i_pin_ring,  // live pin ring values
	output logic      [BSR_W-1:0] o_preload,   // boundary cell output stage
	output logic                  o_extest,    // pins driven from o_preload
	output logic                  o_q_oe       // read data drivers on, sys clk
);

	localparam logic [ID_W-1:0] ID_VALUE = {ID_REV, ID_PART, ID_MAKER, ID_PRESENT};

	bst_state_t       state;
	logic [BSR_W-1:0] pins_s;

	logic [IR_W-1:0]  ir_shift_r, ir_shift_nxt;
	logic [IR_W-1:0]  ir_r, ir_nxt;
	logic             bypass_r, bypass_nxt;
	logic [ID_W-1:0]  id_shift_r, id_shift_nxt;
	logic [BSR_W-1:0] bsr_r, bsr_nxt;
	logic [BSR_W-1:0] preload_r, preload_nxt;
	logic             extest_r, extest_nxt;
	logic             oe_tck_r, oe_tck_nxt;
	logic             tdo_r, tdo_nxt;
	logic             tdo_oe_r, tdo_oe_nxt;
	logic             sel_bsr, sel_id;

	////////////////////////////////////////////////////////////////////////
	// controller and pin ring crossing

	bst_fsm u_fsm (
		.i_tck   (i_tck),
		.i_reset (i_reset),
		.i_tms   (i_tms),
		.o_state (state)
	);

	// pins move on the memory clock; capture is only trusted if held stable
	bst_sync #(.W(BSR_W)) u_pin_sync (
		.i_clk   (i_tck),
		.i_reset (i_reset),
		.i_d     (i_pin_ring),
		.o_q     (pins_s)
	);

	////////////////////////////////////////////////////////////////////////
	// data register selection; reserved codes fall back to bypass

	always_comb begin
		sel_bsr = (ir_r == INS_EXTEST) || (ir_r == INS_SAMPZ)
			|| (ir_r == INS_SAMPLE);
		sel_id  = (ir_r == INS_IDCODE);
	end

	////////////////////////////////////////////////////////////////////////
	// instruction path

	always_comb begin
		ir_shift_nxt = ir_shift_r;
		ir_nxt       = ir_r;
		unique case (state)
			ST_TLR: begin
				ir_nxt = INS_IDCODE;
			end
			ST_CAPIR: begin
				ir_shift_nxt = {ir_r[IR_W-1], IR_CAP_PAT};
			end
			ST_SHIR: begin
				ir_shift_nxt = {i_tdi, ir_shift_r[IR_W-1:1]};
			end
			ST_UPDIR: begin
				ir_nxt = ir_shift_r;
			end
			default: begin
				ir_nxt = ir_r;
			end
		endcase
	end

	always_ff @(posedge i_tck or posedge i_reset) begin
		if (i_reset) begin
			ir_shift_r <= INS_IDCODE;
			ir_r       <= INS_IDCODE;
		end else begin
			ir_shift_r <= ir_shift_nxt;
			ir_r       <= ir_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data registers: only the selected one captures or shifts

	always_comb begin
		bypass_nxt   = bypass_r;
		id_shift_nxt = id_shift_r;
		bsr_nxt      = bsr_r;
		preload_nxt  = preload_r;
		if (state == ST_CAPDR) begin
			if (sel_bsr) begin
				bsr_nxt = pins_s;
			end else if (sel_id) begin
				id_shift_nxt = ID_VALUE;
			end else begin
				bypass_nxt = 1'h0;
			end
		end else if (state == ST_SHDR) begin
			if (sel_bsr) begin
				bsr_nxt = {i_tdi, bsr_r[BSR_W-1:1]};
			end else if (sel_id) begin
				id_shift_nxt = {i_tdi, id_shift_r[ID_W-1:1]};
			end else begin
				bypass_nxt = i_tdi;
			end
		end else if (state == ST_UPDDR && sel_bsr) begin
			preload_nxt = bsr_r;
		end else if (state == ST_TLR) begin
			preload_nxt[OE_CELL] = OE_PRESET;
		end
	end

	always_ff @(posedge i_tck or posedge i_reset) begin
		if (i_reset) begin
			bypass_r            <= 1'h0;
			id_shift_r          <= '0;
			bsr_r               <= '0;
			preload_r           <= '0;
			preload_r[OE_CELL]  <= OE_PRESET;
		end else begin
			bypass_r   <= bypass_nxt;
			id_shift_r <= id_shift_nxt;
			bsr_r      <= bsr_nxt;
			preload_r  <= preload_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin control, computed from next values so outputs leave flip-flops

	always_comb begin
		extest_nxt = (ir_nxt == INS_EXTEST);
		if (ir_nxt == INS_SAMPZ) begin
			oe_tck_nxt = 1'h0;
		end else if (ir_nxt == INS_EXTEST) begin
			oe_tck_nxt = preload_nxt[OE_CELL];
		end else begin
			oe_tck_nxt = 1'h1;
		end
	end

	always_ff @(posedge i_tck or posedge i_reset) begin
		if (i_reset) begin
			extest_r <= 1'h0;
			oe_tck_r <= 1'h1;
		end else begin
			extest_r <= extest_nxt;
			oe_tck_r <= oe_tck_nxt;
		end
	end

	// the enable is a slow level, so a plain two-stage crossing suffices
	bst_sync #(.W(1)) u_oe_sync (
		.i_clk   (i_clk_sys),
		.i_reset (i_reset),
		.i_d     (oe_tck_r),
		.o_q     (o_q_oe)
	);

	////////////////////////////////////////////////////////////////////////
	// serial output on the falling edge gives the tester half a cycle margin

	always_comb begin
		tdo_nxt    = tdo_r;
		tdo_oe_nxt = (state == ST_SHIR) || (state == ST_SHDR);
		if (state == ST_SHIR) begin
			tdo_nxt = ir_shift_r[0];
		end else if (state == ST_SHDR) begin
			if (sel_bsr) begin
				tdo_nxt = bsr_r[0];
			end else if (sel_id) begin
				tdo_nxt = id_shift_r[0];
			end else begin
				tdo_nxt = bypass_r;
			end
		end
	end

	always_ff @(negedge i_tck or posedge i_reset) begin
		if (i_reset) begin
			tdo_r    <= 1'h0;
			tdo_oe_r <= 1'h0;
		end else begin
			tdo_r    <= tdo_nxt;
			tdo_oe_r <= tdo_oe_nxt;
		end
	end

	assign o_tdo     = tdo_r;
	assign o_tdo_oe  = tdo_oe_r;
	assign o_preload = preload_r;
	assign o_extest  = extest_r;

	////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_ir_load;
		(state == ST_SHIR) ##1 (state == ST_EX1IR) ##1 (state == ST_UPDIR);
	endsequence

	property p_ir_idcode;
		@(posedge i_tck) disable iff (i_reset)
		(state == ST_TLR) |=> (ir_r == INS_IDCODE);
	endproperty
	a_ir_idcode: assert property (p_ir_idcode)
		else $error("instruction not preset to identification");

	property p_ir_cap;
		@(posedge i_tck) disable iff (i_reset)
		(state == ST_CAPIR) |=> (ir_shift_r[1:0] == IR_CAP_PAT);
	endproperty
	a_ir_cap: assert property (p_ir_cap)
		else $error("capture pattern missing in instruction");

	property p_ir_update;
		@(posedge i_tck) disable iff (i_reset)
		s_ir_load |=> (ir_r == $past(ir_shift_r));
	endproperty
	a_ir_update: assert property (p_ir_update)
		else $error("instruction not taken at update");

	property p_ir_hold;
		@(posedge i_tck) disable iff (i_reset)
		(state != ST_UPDIR) && (state != ST_TLR) |=> $stable(ir_r);
	endproperty
	a_ir_hold: assert property (p_ir_hold)
		else $error("instruction changed outside update");

	property p_bypass_clr;
		@(posedge i_tck) disable iff (i_reset)
		(state == ST_CAPDR) && (ir_r == INS_BYPASS) |=> !bypass_r;
	endproperty
	a_bypass_clr: assert property (p_bypass_clr)
		else $error("bypass not cleared on capture");

	property p_id_cap;
		@(posedge i_tck) disable iff (i_reset)
		(state == ST_CAPDR) && sel_id |=> (id_shift_r == ID_VALUE) && id_shift_r[0];
	endproperty
	a_id_cap: assert property (p_id_cap)
		else $error("identification value not captured");

	property p_bsr_shift;
		@(posedge i_tck) disable iff (i_reset)
		(state == ST_SHDR) && sel_bsr |=> (bsr_r == {$past(i_tdi), $past(bsr_r[BSR_W-1:1])});
	endproperty
	a_bsr_shift: assert property (p_bsr_shift)
		else $error("boundary scan did not shift toward lsb");

	property p_preload;
		@(posedge i_tck) disable iff (i_reset)
		(state == ST_UPDDR) && sel_bsr |=> (preload_r == $past(bsr_r));
	endproperty
	a_preload: assert property (p_preload)
		else $error("preload stage not updated");

	property p_oe_preset;
		@(posedge i_tck) disable iff (i_reset)
		(state == ST_TLR) |=> preload_r[OE_CELL];
	endproperty
	a_oe_preset: assert property (p_oe_preset)
		else $error("output enable cell not preset in reset");

	property p_sampz_float;
		@(posedge i_tck) disable iff (i_reset)
		(ir_r == INS_SAMPZ) |-> !oe_tck_r;
	endproperty
	a_sampz_float: assert property (p_sampz_float)
		else $error("outputs not floated under high-z sample");

	property p_extest_oe;
		@(posedge i_tck) disable iff (i_reset)
		(ir_r == INS_EXTEST) |-> (oe_tck_r == preload_r[OE_CELL]) && extest_r;
	endproperty
	a_extest_oe: assert property (p_extest_oe)
		else $error("output enable does not follow cell 47");

	property p_tdo_oe;
		@(posedge i_tck) disable iff (i_reset)
		1'h1 |-> (o_tdo_oe == ((state == ST_SHIR) || (state == ST_SHDR)));
	endproperty
	a_tdo_oe: assert property (p_tdo_oe)
		else $error("serial out enable wrong for state");

endmodule

`default_nettype wire

// File: bst_host.sv
`timescale 1ns/10ps
`default_nettype none

// tester side of the scan port; its clock stands still low between frames
module bst_host
	import bst_pkg::*;
(
	input  wire logic i_tdo,      // serial out of the device
	input  wire logic i_tdo_oe,   // device drives serial out
	output logic      o_tck,      // test clock, 30 ns
	output logic      o_tms,      // mode select
	output logic      o_tdi,      // serial data in
	output logic      o_edge_bad  // serial out moved while clock high
);
	logic tdo_last;
	logic tdo_line;
	logic oe_rise;   // drive enable as seen at the last rising clock

	// no pull-up on serial out, so a floating line shows the inverse of its last level
	assign tdo_line = i_tdo_oe ? i_tdo : ~tdo_last;

	// idle levels
	initial begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b1;
		o_edge_bad = 1'b0;
		tdo_last = 1'b0;
	end

	// serial out may only move while the clock is low
	always @(i_tdo) begin
		if (o_tck) begin
			o_edge_bad = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// one clock: inputs change while low, line sampled at the rise
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		o_tms = tms;
		o_tdi = tdi;
		#15;
		o_tck = 1'b1;
		tdo = tdo_line;
		oe_rise = i_tdo_oe;
		if (i_tdo_oe) begin
			tdo_last = i_tdo;
		end
		#15;
		o_tck = 1'b0;
	endtask

	// mode select sequence, first bit first
	task automatic tms_run(input logic [7:0] seq, input int n);
		logic d;
		for (int i = 0; i < n; i++) begin
			step(seq[i], 1'b1, d);
		end
	endtask

	// from idle to shift-ir, shift three bits, stop in exit1-ir
	task automatic ir_scan(input logic [2:0] ins, output logic [2:0] cap);
		tms_run(8'h03, 4);
		for (int i = 0; i < 3; i++) begin
			step(i == 2, ins[i], cap[i]);
		end
	endtask

	// exit1 to update, then back to idle
	task automatic upd_idle();
		tms_run(8'h01, 2);
	endtask

	// full-length data scan; shorter registers show up as delayed input data
	task automatic dr_scan(input logic [BSR_W-1:0] din, output logic [BSR_W-1:0] dout,
		output logic oe_all);
		tms_run(8'h01, 3);
		oe_all = 1'b1;
		// the enable moves on the falling edge, so only its value at the rise counts
		for (int i = 0; i < BSR_W; i++) begin
			step(i == BSR_W - 1, din[i], dout[i]);
			oe_all = oe_all & oe_rise;
		end
		upd_idle();
	endtask
endmodule

`default_nettype wire

// File: bst_tb.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
	import bst_pkg::*;
	localparam logic [2:0]  REV   = 3'h5;      // arbitrary value
	localparam logic [16:0] PART  = 17'h1B2C3; // arbitrary value
	localparam logic [10:0] MAKER = 11'h155;   // arbitrary value
	localparam logic [ID_W-1:0] ID_EXP = {REV, PART, MAKER, ID_PRESENT};

	logic             clk_sys;
	logic             reset;
	logic             tck, tms, tdi, tdo, tdo_oe, extest, q_oe, edge_bad;
	logic [BSR_W-1:0] pin_ring;
	logic [BSR_W-1:0] preload;
	int               mismatches = 0;
	int               checks = 0;
	int               cycles = 0;

	bst_top #(.ID_REV(REV), .ID_PART(PART), .ID_MAKER(MAKER)) bst_top_i (
		.i_clk_sys(clk_sys), .i_reset(reset), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
		.o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_pin_ring(pin_ring), .o_preload(preload),
		.o_extest(extest), .o_q_oe(q_oe));

	bst_host bst_host_i (.i_tdo(tdo), .i_tdo_oe(tdo_oe), .o_tck(tck), .o_tms(tms),
		.o_tdi(tdi), .o_edge_bad(edge_bad));

	// memory-side clock, 25 ns
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// hang guard, the tests need well under a tenth of this
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [BSR_W-1:0] seen, input logic [BSR_W-1:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: saw %0h wanted %0h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	function automatic logic [BSR_W-1:0] pat(input int s);
		pat = BSR_W'({4{32'h6D3B91E5}} >> s);
	endfunction

	// what a full-length scan returns: register contents then the delayed input
	function automatic logic [BSR_W-1:0] dr_exp(input logic [2:0] c, input logic [BSR_W-1:0] d);
		case (c)
			INS_IDCODE: dr_exp = {d[BSR_W-ID_W-1:0], ID_EXP};
			INS_BYPASS: dr_exp = {d[BSR_W-2:0], 1'b0};
			default:    dr_exp = pin_ring;
		endcase
	endfunction

	function automatic logic q_exp(input logic [2:0] c, input logic [BSR_W-1:0] p);
		q_exp = (c == INS_SAMPZ) ? 1'b0 : (c == INS_EXTEST) ? p[OE_CELL] : 1'b1;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		logic [2:0]       cap;
		logic [BSR_W-1:0] din;
		logic [BSR_W-1:0] dout;
		logic [BSR_W-1:0] prel;
		logic             oe_all;
		logic [2:0]       last;
		logic [2:0]       codes [5] = '{INS_SAMPLE, INS_EXTEST, INS_SAMPZ, INS_IDCODE,
			INS_BYPASS};
		reset = 1'b1;
		pin_ring = pat(7);
		prel = BSR_W'(1) << OE_CELL;
		last = INS_IDCODE;
		fork
			bst_host_i.tms_run(8'h1F, 5);
			repeat (10) @(negedge clk_sys);
		join
		check(BSR_W'(tdo_oe), BSR_W'(1'h0));
		check(preload, prel);
		reset = 1'b0;
		repeat (4) @(negedge clk_sys);
		check(BSR_W'({extest, q_oe}), BSR_W'(2'h1));
		bst_host_i.tms_run(8'h00, 1);
		din = pat(3);
		bst_host_i.dr_scan(din, dout, oe_all);
		check(dout, dr_exp(INS_IDCODE, din));
		check(BSR_W'({oe_all, tdo_oe}), BSR_W'(2'h2));
		$display("test power-up identification done");
		for (int k = 0; k < 5; k++) begin
			bst_host_i.ir_scan(codes[k], cap);
			check(BSR_W'(cap[1:0]), BSR_W'(IR_CAP_PAT));
			check(BSR_W'(extest), BSR_W'(last == INS_EXTEST));
			bst_host_i.upd_idle();
			check(BSR_W'(extest), BSR_W'(codes[k] == INS_EXTEST));
			repeat (4) @(negedge clk_sys);
			check(BSR_W'(q_oe), BSR_W'(q_exp(codes[k], prel)));
			din = pat(5 * k + 11);
			bst_host_i.dr_scan(din, dout, oe_all);
			check(dout, dr_exp(codes[k], din));
			if (codes[k] != INS_IDCODE && codes[k] != INS_BYPASS) begin
				prel = din;
			end
			check(preload, prel);
			repeat (4) @(negedge clk_sys);
			check(BSR_W'(q_oe), BSR_W'(q_exp(codes[k], prel)));
			last = codes[k];
			$display("test instruction %0d done", codes[k]);
		end
		bst_host_i.tms_run(8'h1F, 5);
		prel[OE_CELL] = OE_PRESET;
		check(preload, prel);
		check(BSR_W'(extest), BSR_W'(1'h0));
		bst_host_i.tms_run(8'h00, 1);
		din = pat(40);
		bst_host_i.dr_scan(din, dout, oe_all);
		check(dout, dr_exp(INS_IDCODE, din));
		check(BSR_W'(edge_bad), BSR_W'(1'h0));
		$display("test mode-select reset done");
		complete_run();
	end
endmodule

`default_nettype wire
